/* File: hw/i2c_slave_consts.svh */
// Constants for the masked-address two-wire slave core.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

// Bit count of one byte on the wire
`define I2CS_BYTE_BITS 4'h8
// Cleared byte value after reset
`define I2CS_RST_BYTE 8'h00
// Clock release bit comes out of reset set, so the clock is free
`define I2CS_RST_RELEASE 1'b1
// Own address value after reset
`define I2CS_RST_OWN_ADDR 8'h00
// Upper two address bits always compared exactly
`define I2CS_CARE_HI 2'h3

`endif

/* File: hw/i2c_slave_pkg.sv */
// Types shared by the slave core and its receive buffer.
// Assumes the constants header is compiled alongside.
package i2c_slave_pkg;

	// Slave bus sequencer states
	typedef enum logic [2:0] {
		S_IDLE,
		S_RECV,
		S_ACK,
		S_HOLD,
		S_SEND,
		S_MACK,
		S_MEND
	} slave_state_e;

	// Which byte of a transfer is on the wire
	typedef enum logic [1:0] {
		P_FIRST,
		P_LOW,
		P_DATA
	} byte_phase_e;

	// One received byte as handed to the consumer
	typedef struct packed {
		logic isAddress;
		logic [7:0] data;
	} rx_word_s;

endpackage

/* File: hw/rx_word_buffer.sv */
// Two-entry buffer for received bytes with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module rx_word_buffer
	import i2c_slave_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input rx_word_s inWord,
	input wire logic inValid,
	output logic inReady,
	output rx_word_s outWord,
	output logic outValid,
	input wire logic outReady
);

	rx_word_s tail_q; // Second entry
	logic tailValid_q; // Second entry occupied
	logic push; // Word accepted this cycle
	logic pop; // Word taken this cycle

	// Full only when both entries are taken
	assign inReady = !tailValid_q;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Head is the output register, tail refills it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			outValid <= 1'b0;
			tailValid_q <= 1'b0;
			outWord <= '0;
			tail_q <= '0;
		end else if (pop) begin
			if (tailValid_q) begin
				outWord <= tail_q;
				tailValid_q <= 1'b0;
			end else begin
				outWord <= inWord;
				outValid <= push;
			end
		end else if (push) begin
			if (!outValid) begin
				outWord <= inWord;
				outValid <= 1'b1;
			end else begin
				tail_q <= inWord;
				tailValid_q <= 1'b1;
			end
		end
	end

endmodule // rx_word_buffer

/* File: hw/i2c_slave_mask_stretch.sv */
// Two-wire slave core: masked address match, receive, transmit, stretching.
// Assumes open-drain pins resolved outside; link pins are asynchronous.
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"

module i2c_slave_mask_stretch
	import i2c_slave_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic moduleEnable,
	input wire logic tenBitMode,
	input wire logic stretchEnable,
	input wire logic [4:0] addrMaskBits,
	input wire logic ownAddrWrite,
	input wire logic [7:0] ownAddrData,
	input wire logic bufWrite,
	input wire logic [7:0] bufWriteData,
	input wire logic bufRead,
	input wire logic clockReleaseSet,
	input wire logic overflowClear,
	input wire logic eventClear,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe_n,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_n,
	output logic [7:0] rxTxBuffer_q,
	output logic bufferFull_q,
	output logic receiveOverflow_q,
	output logic serialEvent_q,
	output logic readNotWrite_q,
	output logic updateAddress_q,
	output logic clockRelease_q,
	output rx_word_s rxWord,
	output logic rxValid,
	input wire logic rxReady
);

	// 7-bit care mask: upper bits exact, bit zero is direction
	function automatic logic match7(input logic [7:0] sr, input logic [7:0] own,
		input logic [4:0] m);
		logic [7:0] care;
		care = {`I2CS_CARE_HI, ~m, 1'b0};
		return ((sr ^ own) & care) == 8'h00;
	endfunction

	// 10-bit low byte: lowest mask bit covers two bits
	function automatic logic match10(input logic [7:0] sr, input logic [7:0] own,
		input logic [4:0] m);
		logic [7:0] care;
		care = {`I2CS_CARE_HI, ~m[4:1], ~m[0], ~m[0]};
		return ((sr ^ own) & care) == 8'h00;
	endfunction

	logic [1:0] pinIn; // Raw pins, clock then data
	logic [1:0] pinMeta_q; // First synchroniser stage
	logic [1:0] pinSync_q; // Second synchroniser stage
	logic [1:0] pinPrev_q; // Previous synchronised level
	logic sclSync; // Synchronised clock level
	logic sdaSync; // Synchronised data level
	logic sclRise; // Clock rising edge
	logic sclFall; // Clock falling edge
	logic startSeen; // Start or repeated start
	logic stopSeen; // Stop condition
	slave_state_e st_q; // Sequencer state
	byte_phase_e phase_q; // Byte position in transfer
	byte_phase_e nextPhase; // Phase after this byte
	logic [3:0] bitCnt_q; // Bits seen in this byte
	logic [7:0] shiftReg_q; // Incoming shift register
	logic [7:0] txShift_q; // Outgoing shift register
	logic [7:0] ownAddr_q; // Own address register
	logic txReq_q; // Transfer is a slave transmit
	logic byteWasData_q; // Last received byte was data
	logic loSeen_q; // 10-bit low address matched
	logic matchNow; // Current byte is for us
	logic ackNow; // Current byte gets an ack
	logic readReq; // Address asks for transmit
	logic uaSetNow; // Byte sets update flag
	logic byteDone; // Eighth falling edge in receive
	logic ackDone; // Ninth falling edge after our ack slot
	logic txLast; // Eighth falling edge in transmit
	logic mendFall; // Ninth falling edge in transmit
	logic holdNow; // Stretch condition in hold state
	logic pushPend_q; // Byte waiting for buffer room
	rx_word_s pushWord_q; // Byte to hand over
	logic bufInReady; // Buffer can take a byte
	logic bfSet; // Buffer full set
	logic bfClr; // Buffer full clear
	logic ckpClr; // Hardware clears release bit

	// Two-flop synchronisers on both link pins
	assign pinIn = {sclIn, sdaIn};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					pinMeta_q[gi] <= 1'b1;
					pinSync_q[gi] <= 1'b1;
					pinPrev_q[gi] <= 1'b1;
				end else begin
					pinMeta_q[gi] <= pinIn[gi];
					pinSync_q[gi] <= pinMeta_q[gi];
					pinPrev_q[gi] <= pinSync_q[gi];
				end
			end
		end
	endgenerate

	// Edge and bus condition detection
	assign sclSync = pinSync_q[1];
	assign sdaSync = pinSync_q[0];
	assign sclRise = sclSync && !pinPrev_q[1];
	assign sclFall = !sclSync && pinPrev_q[1];
	assign startSeen = sclSync && pinPrev_q[1] && pinPrev_q[0] && !sdaSync;
	assign stopSeen = sclSync && pinPrev_q[1] && !pinPrev_q[0] && sdaSync;

	// Byte boundary strobes
	assign byteDone = (st_q == S_RECV) && sclFall && (bitCnt_q == `I2CS_BYTE_BITS);
	assign ackDone = (st_q == S_ACK) && sclFall;
	assign txLast = (st_q == S_SEND) && sclFall && (bitCnt_q == `I2CS_BYTE_BITS);
	assign mendFall = (st_q == S_MEND) && sclFall;
	assign holdNow = !clockRelease_q || updateAddress_q || pushPend_q;

	// Address decode for the byte in the shifter
	always_comb begin
		matchNow = 1'b0;
		readReq = 1'b0;
		uaSetNow = 1'b0;
		nextPhase = P_DATA;
		case (phase_q)
			P_FIRST: begin
				if (!tenBitMode) begin
					matchNow = match7(shiftReg_q, ownAddr_q, addrMaskBits);
					readReq = shiftReg_q[0];
				end else if (shiftReg_q[7:1] == ownAddr_q[7:1]) begin
					if (!shiftReg_q[0]) begin
						matchNow = 1'b1;
						uaSetNow = 1'b1;
						nextPhase = P_LOW;
					end else if (loSeen_q) begin
						matchNow = 1'b1;
						readReq = 1'b1;
					end
				end
			end
			P_LOW: begin
				matchNow = match10(shiftReg_q, ownAddr_q, addrMaskBits);
				uaSetNow = 1'b1;
			end
			P_DATA: begin
				matchNow = 1'b1;
			end
			default: begin
				matchNow = 1'b0;
			end
		endcase
		ackNow = matchNow && !bufferFull_q && !receiveOverflow_q;
	end

	// Bus sequencer
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			st_q <= S_IDLE;
			phase_q <= P_FIRST;
			bitCnt_q <= 4'h0;
			shiftReg_q <= `I2CS_RST_BYTE;
			txReq_q <= 1'b0;
			byteWasData_q <= 1'b0;
			loSeen_q <= 1'b0;
			sdaOe_n <= 1'b1;
		end else if (stopSeen) begin
			st_q <= S_IDLE;
			loSeen_q <= 1'b0;
			txReq_q <= 1'b0;
			sdaOe_n <= 1'b1;
		end else if (startSeen) begin
			st_q <= S_RECV;
			phase_q <= P_FIRST;
			bitCnt_q <= 4'h0;
			txReq_q <= 1'b0;
			sdaOe_n <= 1'b1;
		end else begin
			case (st_q)
				S_RECV: begin
					if (sclRise) begin
						shiftReg_q <= {shiftReg_q[6:0], sdaSync};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (byteDone) begin
						if (matchNow) begin
							st_q <= S_ACK;
							sdaOe_n <= !ackNow;
							txReq_q <= readReq;
							byteWasData_q <= (phase_q == P_DATA);
							phase_q <= nextPhase;
							if (phase_q == P_LOW) begin
								loSeen_q <= 1'b1;
							end
						end else begin
							st_q <= S_IDLE;
						end
					end
				end
				S_ACK: begin
					if (sclFall) begin
						sdaOe_n <= 1'b1;
						st_q <= S_HOLD;
					end
				end
				S_HOLD: begin
					if (!holdNow) begin
						bitCnt_q <= 4'h0;
						if (txReq_q) begin
							st_q <= S_SEND;
							sdaOe_n <= txShift_q[7];
						end else begin
							st_q <= S_RECV;
						end
					end
				end
				S_SEND: begin
					if (sclRise) begin
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (txLast) begin
						sdaOe_n <= 1'b1;
						st_q <= S_MACK;
					end else if (sclFall) begin
						sdaOe_n <= txShift_q[6];
					end
				end
				S_MACK: begin
					if (sclRise) begin
						// A nack still waits for the ninth fall to flag the byte
						st_q <= S_MEND;
						if (sdaSync) begin
							txReq_q <= 1'b0;
						end
					end
				end
				S_MEND: begin
					if (sclFall && txReq_q) begin
						st_q <= S_HOLD;
					end else if (sclFall) begin
						st_q <= S_IDLE;
					end
				end
				S_IDLE: begin
					sdaOe_n <= 1'b1;
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// Clock stretch drive, only once the line is seen low
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			sclOe_n <= 1'b1;
		end else begin
			sclOe_n <= !((st_q == S_HOLD) && holdNow && !sclSync);
		end
	end

	// Open-drain pins only ever pull low
	always_ff @(posedge ref_clk) begin
		sclOut <= 1'b0;
		sdaOut <= 1'b0;
	end

	// Own address register, writing it clears the update flag
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ownAddr_q <= `I2CS_RST_OWN_ADDR;
		end else if (ownAddrWrite) begin
			ownAddr_q <= ownAddrData;
		end
	end

	// Outgoing shifter, loaded with the buffer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txShift_q <= `I2CS_RST_BYTE;
		end else if (bufWrite) begin
			txShift_q <= bufWriteData;
		end else if ((st_q == S_SEND) && sclFall && !txLast) begin
			txShift_q <= {txShift_q[6:0], 1'b0};
		end
	end

	// Buffer contents and full flag
	assign bfSet = (byteDone && ackNow) || bufWrite;
	assign bfClr = bufRead || txLast;
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			bufferFull_q <= 1'b0;
			rxTxBuffer_q <= `I2CS_RST_BYTE;
		end else begin
			bufferFull_q <= bfSet || (bufferFull_q && !bfClr);
			if (byteDone && ackNow) begin
				rxTxBuffer_q <= shiftReg_q;
			end else if (bufWrite) begin
				rxTxBuffer_q <= bufWriteData;
			end
		end
	end

	// Overflow: data byte arrives with buffer still full
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			receiveOverflow_q <= 1'b0;
		end else begin
			receiveOverflow_q <= (byteDone && (phase_q == P_DATA) && bufferFull_q)
				|| (receiveOverflow_q && !overflowClear);
		end
	end

	// Event flag on the ninth falling edge of each matched byte, set beats clear
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			serialEvent_q <= 1'b0;
		end else begin
			serialEvent_q <= ackDone || mendFall || (serialEvent_q && !eventClear);
		end
	end

	// Direction bit, cleared when the master ends a read
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			readNotWrite_q <= 1'b0;
		end else if ((st_q == S_MACK) && sclRise && sdaSync) begin
			readNotWrite_q <= 1'b0;
		end else if (byteDone && matchNow && (phase_q == P_FIRST)) begin
			readNotWrite_q <= shiftReg_q[0];
		end
	end

	// Update-address flag, set beats the own address write
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			updateAddress_q <= 1'b0;
		end else begin
			updateAddress_q <= (byteDone && matchNow && uaSetNow)
				|| (updateAddress_q && !ownAddrWrite);
		end
	end

	// Release bit: hardware clears, software set wins
	assign ckpClr = (ackDone && (txReq_q
		|| (byteWasData_q && stretchEnable && bufferFull_q)))
		|| (mendFall && txReq_q && !bufferFull_q);
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			clockRelease_q <= `I2CS_RST_RELEASE;
		end else begin
			clockRelease_q <= clockReleaseSet || (clockRelease_q && !ckpClr);
		end
	end

	// Hand each acknowledged byte to the buffer, stretching if it is full
	always_ff @(posedge ref_clk) begin
		if (rst || !moduleEnable) begin
			pushPend_q <= 1'b0;
			pushWord_q <= '0;
		end else if (byteDone && ackNow) begin
			pushPend_q <= 1'b1;
			pushWord_q <= '{isAddress: (phase_q != P_DATA), data: shiftReg_q};
		end else if (bufInReady) begin
			pushPend_q <= 1'b0;
		end
	end

	rx_word_buffer u_rx_buffer (
		.ref_clk(ref_clk),
		.rst(rst),
		.inWord(pushWord_q),
		.inValid(pushPend_q),
		.inReady(bufInReady),
		.outWord(rxWord),
		.outValid(rxValid),
		.outReady(rxReady)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst || !moduleEnable);

	sequence s_full_addr;
		byteDone && (phase_q != P_DATA) && (bufferFull_q || receiveOverflow_q);
	endsequence
	sequence s_master_nack;
		(st_q == S_MACK) && sclRise && sdaSync;
	endsequence

	a_addr_nack_full: assert property (s_full_addr |=> sdaOe_n [*1] ##1 1'b1)
		else $error("address acked while buffer full");
	a_write_match_load: assert property (byteDone && ackNow && !shiftReg_q[0] && !phase_q[1]
		|=> rxTxBuffer_q == $past(shiftReg_q) && !readNotWrite_q && !sdaOe_n)
		else $error("write match did not load and ack");
	a_event_ninth: assert property ((ackDone || mendFall) |=> serialEvent_q)
		else $error("event flag missing on ninth edge");
	a_scl_low_first: assert property ($fell(sclOe_n) |-> !$past(sclSync))
		else $error("clock pulled low while high");
	a_rx_stretch_clr: assert property (ackDone && byteWasData_q && stretchEnable && bufferFull_q
		&& !clockReleaseSet |=> !clockRelease_q)
		else $error("receive stretch did not clear release");
	a_tx_stretch_clr: assert property (mendFall && txReq_q && !bufferFull_q && !clockReleaseSet
		|=> !clockRelease_q ##1 (st_q == S_HOLD || clockRelease_q))
		else $error("transmit stretch did not clear release");
	a_nack_ends: assert property (s_master_nack |=> (st_q == S_MEND) && !txReq_q && !readNotWrite_q)
		else $error("master nack did not end transfer");
	a_ua_after_addr: assert property (byteDone && matchNow && uaSetNow && !ownAddrWrite
		|=> updateAddress_q ##1 (updateAddress_q || $past(ownAddrWrite)))
		else $error("update flag not set after address");
	a_release_accept: assert property (clockReleaseSet |=> clockRelease_q)
		else $error("software release not accepted");

endmodule // i2c_slave_mask_stretch

/* File: test/i2c_master_model.sv */
// Behavioural two-wire bus master driving open-drain enables.
// Assumes the bench resolves both wires with pull-ups; clock idles high.
`timescale 1ns/1ps

module i2c_master_model (
	input wire logic scl,
	input wire logic sda,
	output logic mSclOe_n,
	output logic mSdaOe_n,
	output int glitches
);
	// Idle: both lines released, clock stands still
	initial begin
		mSclOe_n = 1'b1;
		mSdaOe_n = 1'b1;
		glitches = 0;
	end
	// Release clock and wait out any stretch by the slave
	task automatic sclHigh();
		int n;
		n = 0;
		mSclOe_n = 1'b1;
		#8;
		while (scl !== 1'b1 && n < 40000) begin
			#8;
			n++;
		end
	endtask
	// One bit driven by the master
	task automatic bitOut(input logic b);
		mSdaOe_n = b;
		#40;
		sclHigh();
		#72;
		mSclOe_n = 1'b0;
		#40;
	endtask
	// One bit from the slave; data must hold while clock is high
	task automatic bitIn(output logic b);
		mSdaOe_n = 1'b1;
		#40;
		sclHigh();
		b = sda;
		#72;
		if (sda !== b) glitches++;
		mSclOe_n = 1'b0;
		#40;
	endtask
	// Start: data falls while clock high
	task automatic start();
		#2;
		mSdaOe_n = 1'b0;
		#80;
		mSclOe_n = 1'b0;
		#40;
	endtask
	// Stop: data rises while clock high
	task automatic stop();
		#2;
		mSdaOe_n = 1'b0;
		#40;
		sclHigh();
		#72;
		mSdaOe_n = 1'b1;
		#160;
	endtask
	// Repeated start: free data, let the clock rise, then start
	task automatic restart();
		#2;
		mSdaOe_n = 1'b1;
		#40;
		sclHigh();
		#40;
		start();
	endtask
	// Byte out, MSB first, then the slave's acknowledge
	task automatic writeByte(input logic [7:0] d, output logic ack);
		logic b;
		#2;
		for (int i = 7; i >= 0; i--) bitOut(d[i]);
		bitIn(b);
		ack = !b;
	endtask
	// Byte in, MSB first, then our acknowledge or not
	task automatic readByte(input logic ackIt, output logic [7:0] d);
		#2;
		for (int i = 7; i >= 0; i--) bitIn(d[i]);
		bitOut(!ackIt);
	endtask
endmodule // i2c_master_model

/* File: test/i2c_slave_mask_stretch_tb.sv */
// Self-checking bench for the masked-address two-wire slave core.
// Assumes package, buffer, core and master model are compiled first.
`timescale 1ns/1ps

module i2c_slave_mask_stretch_tb;
	import i2c_slave_pkg::*;
	logic ref_clk = 1'b0; // System clock
	logic rst = 1'b1; // Synchronous reset
	logic moduleEnable = 1'b0;
	logic tenBitMode = 1'b0;
	logic stretchEnable = 1'b0;
	logic [4:0] addrMaskBits = 5'h00;
	logic [7:0] ownAddrData = 8'h00;
	logic [7:0] bufWriteData = 8'h00;
	logic [5:0] swp = 6'h00; // Software strobes
	logic rxReady = 1'b0;
	logic stall = 1'b1; // Consumer stalled at first
	logic sclOe_n, sdaOe_n, mSclOe_n, mSdaOe_n, rxValid, sclOut, sdaOut;
	logic bufferFull_q, receiveOverflow_q, serialEvent_q;
	logic readNotWrite_q, updateAddress_q, clockRelease_q;
	logic [7:0] rxTxBuffer_q;
	rx_word_s rxWord;
	rx_word_s expQ[$]; // Expected stream words
	int glitches;
	int errCount = 0;
	int nTests = 0;
	int cycles = 0;
	int seed = 32'h61595019;
	wire scl = sclOe_n & mSclOe_n; // Open drain with pull-up
	wire sda = sdaOe_n & mSdaOe_n;

	always #4 ref_clk = ~ref_clk;

	i2c_slave_mask_stretch i2c_slave_mask_stretch_i (
		.ref_clk, .rst, .moduleEnable, .tenBitMode, .stretchEnable, .addrMaskBits,
		.ownAddrWrite(swp[4]), .ownAddrData, .bufWrite(swp[5]), .bufWriteData,
		.bufRead(swp[0]), .clockReleaseSet(swp[1]), .overflowClear(swp[2]),
		.eventClear(swp[3]), .sclIn(scl), .sclOut, .sclOe_n, .sdaIn(sda), .sdaOut,
		.sdaOe_n, .rxTxBuffer_q, .bufferFull_q, .receiveOverflow_q, .serialEvent_q,
		.readNotWrite_q, .updateAddress_q, .clockRelease_q, .rxWord, .rxValid, .rxReady
	);
	i2c_master_model master_i (.scl, .sda, .mSclOe_n, .mSdaOe_n, .glitches);

	// Compare and count
	task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
		nTests++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One-cycle software strobe
	task automatic sw(input int k);
		@(posedge ref_clk);
		swp[k] <= 1'b1;
		@(posedge ref_clk);
		swp[k] <= 1'b0;
	endtask
	// Master sends a byte; optional buffer read meanwhile
	task automatic sendB(input logic [7:0] b, input logic expAck, input logic isAddr,
		input logic rd);
		logic ack;
		// Note the word before it can reach the stream output
		if (expAck) expQ.push_back({isAddr, b});
		fork
			master_i.writeByte(b, ack);
			if (rd) sw(0);
		join
		repeat (4) @(posedge ref_clk);
		check(9'(ack), 9'(expAck), "acknowledge");
		if (expAck) begin
			check(9'(serialEvent_q), 9'h001, "byte event");
			sw(3);
		end
	endtask
	// Stop while software frees the clock
	task automatic stopRel();
		fork
			master_i.stop();
			begin
				sw(0);
				sw(3);
				sw(1);
			end
		join
	endtask

	// Stream watcher: oldest note against each accepted word
	always @(posedge ref_clk) begin
		if (!rst && rxValid === 1'b1 && rxReady === 1'b1) begin
			if (expQ.size() == 0)
				check(9'h1ff, 9'h000, "extra word");
			else
				check(rxWord, expQ.pop_front(), "stream word");
		end
	end
	// Random consumer stalls and the hang limit
	always @(posedge ref_clk) begin
		rxReady <= stall ? 1'b0 : 1'($random(seed));
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errCount++;
			$display("BAD %0t run too long", $time);
			results();
		end
	end

	// Main sequence
	initial begin
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] got;
		logic expAck;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		moduleEnable <= 1'b1;
		@(posedge ref_clk);
		check(9'({clockRelease_q, sclOe_n, sdaOe_n, bufferFull_q}), 9'h00e, "reset");
		check(9'({sclOut, sdaOut}), 9'h000, "pull level");
		ownAddrData <= 8'ha0;
		addrMaskBits <= 5'h07;
		stretchEnable <= 1'b1;
		sw(4);
		for (int i = 0; i < 8; i++) begin
			a = (i % 2) ? (8'($random(seed)) & 8'hfe) : (8'ha0 | (8'($random(seed)) & 8'h0e));
			expAck = ((a ^ 8'ha0) & 8'hf0) == 8'h00;
			master_i.start();
			sendB(a, expAck, 1'b1, 1'b0);
			if (expAck) begin
				check(9'(rxTxBuffer_q), 9'(a), "address held");
				check(9'(readNotWrite_q), 9'h000, "write direction");
				d = 8'($random(seed));
				sendB(d, 1'b1, 1'b0, 1'b1);
				check(9'({clockRelease_q, sclOe_n}), 9'h000, "receive stretch");
				check(9'(rxTxBuffer_q), 9'(d), "data held");
			end
			stopRel();
			stall <= 1'b0;
		end
		// Buffer read between the eighth and ninth falls: no stretch
		master_i.start();
		sendB(8'ha4, 1'b1, 1'b1, 1'b0);
		fork
			sendB(8'h3e, 1'b1, 1'b0, 1'b1);
			begin
				repeat (166) @(posedge ref_clk);
				sw(0);
			end
		join
		check(9'({clockRelease_q, sclOe_n}), 9'h003, "early read");
		stopRel();
		$display("masked write done");
		stretchEnable <= 1'b0;
		master_i.start();
		sendB(8'ha2, 1'b1, 1'b1, 1'b0);
		sendB(8'h5a, 1'b0, 1'b0, 1'b0);
		check(9'(receiveOverflow_q), 9'h001, "overflow");
		stopRel();
		master_i.start();
		sendB(8'ha2, 1'b0, 1'b1, 1'b1);
		stopRel();
		sw(2);
		@(posedge ref_clk);
		check(9'(receiveOverflow_q), 9'h000, "overflow cleared");
		$display("overflow done");
		master_i.start();
		sendB(8'ha5, 1'b1, 1'b1, 1'b0);
		check(9'({readNotWrite_q, sclOe_n}), 9'h002, "read hold");
		for (int k = 0; k < 2; k++) begin
			d = 8'($random(seed));
			fork
				master_i.readByte(k == 0, got);
				begin
					sw(0);
					bufWriteData <= d;
					sw(5);
					sw(1);
				end
			join
			repeat (4) @(posedge ref_clk);
			check(9'(got), 9'(d), "sent byte");
			check(9'(serialEvent_q), 9'h001, "send event");
			sw(3);
			if (k == 0)
				check(9'({clockRelease_q, sclOe_n}), 9'h000, "send stretch");
		end
		check(9'(readNotWrite_q), 9'h000, "end on nack");
		check(9'(glitches), 9'h000, "data steady");
		stopRel();
		$display("transmit done");
		tenBitMode <= 1'b1;
		stretchEnable <= 1'b1;
		addrMaskBits <= 5'h1f;
		ownAddrData <= 8'hf2;
		sw(4);
		master_i.start();
		sendB(8'hf0, 1'b0, 1'b1, 1'b1);
		stopRel();
		addrMaskBits <= 5'h01;
		master_i.start();
		sendB(8'hf2, 1'b1, 1'b1, 1'b0);
		check(9'({updateAddress_q, clockRelease_q, sclOe_n}), 9'h006, "upper hold");
		fork
			sendB(8'h54, 1'b1, 1'b1, 1'b1);
			begin
				ownAddrData <= 8'h57;
				sw(4);
			end
		join
		check(9'({updateAddress_q, clockRelease_q, sclOe_n}), 9'h006, "lower hold");
		fork
			sendB(8'h3c, 1'b1, 1'b0, 1'b1);
			begin
				ownAddrData <= 8'hf2;
				sw(4);
			end
		join
		check(9'({updateAddress_q, clockRelease_q}), 9'h000, "ten-bit data");
		// Repeated start with the high byte for reading
		fork
			master_i.restart();
			begin
				sw(0);
				sw(3);
				sw(1);
			end
		join
		sendB(8'hf3, 1'b1, 1'b1, 1'b0);
		check(9'({readNotWrite_q, sclOe_n}), 9'h002, "ten-bit read");
		fork
			master_i.readByte(1'b0, got);
			begin
				bufWriteData <= 8'h96;
				sw(5);
				sw(1);
			end
		join
		repeat (4) @(posedge ref_clk);
		check(9'(got), 9'h096, "ten-bit sent");
		stopRel();
		$display("ten-bit done");
		repeat (100) @(posedge ref_clk);
		check(9'(expQ.size()), 9'h000, "stream drained");
		bufWriteData <= 8'h11;
		sw(5);
		@(posedge ref_clk);
		check(9'(bufferFull_q), 9'h001, "software load");
		moduleEnable <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(9'({bufferFull_q, clockRelease_q, sclOe_n}), 9'h003, "disable");
		$display("disable done");
		results();
	end
endmodule // i2c_slave_mask_stretch_tb
